/* File: osl_top.sv */
// Status and control logic of a pluggable optical module.
// Operation
// - Laser fault raises fault output, laser off.
// - Fault output low normal, high on fault.
// - Fault stays latched after condition disappears.
// - Only shutoff toggle or power cycle clears.
// - Fault mirrored in status byte bit 2.
// - Eye safety monitor disables unsafe transmitter.
// - Clock recovery used only with speed high.
// - Signal lost high when input unusable.
// - Signal lost mirrored in status bit 1.
// - Shutoff high turns optics off.
// - Software shutoff bit ORed with pin.
// - Clock recovery locks within 500 us.
`default_nettype none
`include "osl_map.svh"
module osl_top #(
  parameter int unsigned LOCK_CYCLES = `OSL_LOCK_TIME_US * `OSL_CLK_MHZ
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic TX_DISABLE_PIN,
  input wire logic LASER_FAULT,
  input wire logic EYE_UNSAFE,
  input wire logic TRANSITION_OK,
  input wire logic RX_SPEED_PIN,
  input wire logic RX_TRAFFIC_VALID,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic TX_FAULT_O,
  output logic TX_FAULT_OE,
  output logic LASER_ENABLE,
  output logic OPTICAL_SIGNAL_LOST,
  output logic RX_CDR_ENGAGE,
  output logic RX_CDR_LOCKED,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID
);
  osl_pkg::osl_state_t st;
  osl_pkg::osl_state_t next_st;
  logic fault_set;
  logic fault_clr;
  logic hit;
  logic [7:0] status;

  function automatic logic is_status(logic [7:0] addr);
    return addr == `OSL_STATUS_OFFSET;
  endfunction

  always_comb begin
    next_st = st;
    hit = is_status(REG_ADDR);
    fault_set = LASER_FAULT | EYE_UNSAFE;
    fault_clr = st.dis_prev & ~TX_DISABLE_PIN;
    // latch holds fault; a new fault wins over the clear.
    next_st.fault = fault_set | (st.fault & ~fault_clr);
    next_st.dis_prev = TX_DISABLE_PIN;
    if (REG_WR && hit) begin
      next_st.soft_dis = REG_WDATA[`OSL_BIT_SOFT_DIS];
    end
    next_st.laser_en = ~(TX_DISABLE_PIN | next_st.soft_dis) & ~next_st.fault & ~EYE_UNSAFE;
    next_st.fault_oe = ~next_st.fault;
    next_st.los = ~TRANSITION_OK;
    next_st.cdr_en = RX_SPEED_PIN;
    status = `OSL_STATUS_RESET;
    status[`OSL_BIT_DIS_STATE] = TX_DISABLE_PIN | st.soft_dis;
    status[`OSL_BIT_SOFT_DIS] = st.soft_dis;
    status[`OSL_BIT_TX_FAULT] = st.fault;
    status[`OSL_BIT_SIG_LOST] = st.los;
    next_st.rvalid = REG_RD;
    if (REG_RD) begin
      next_st.rdata = hit ? status : `OSL_UNMAPPED_READ;
    end
  end

  // The shutoff pin resets as high because its pull-up keeps the laser dark until driven.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st.fault <= 1'b0;
      st.dis_prev <= 1'b1;
      st.soft_dis <= 1'b0;
      st.laser_en <= 1'b0;
      st.los <= 1'b1;
      st.fault_oe <= 1'b1;
      st.cdr_en <= 1'b0;
      st.rdata <= `OSL_STATUS_RESET;
      st.rvalid <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  osl_lock_timer #(.LIMIT(LOCK_CYCLES)) lock_timer (
    .clk(CLK),
    .rst(RESET),
    .en(st.cdr_en & RX_TRAFFIC_VALID),
    .done(RX_CDR_LOCKED)
  );

  // The pin only ever sinks; the host pull-up makes the high level.
  assign TX_FAULT_O = 1'b0;
  assign TX_FAULT_OE = st.fault_oe;
  assign LASER_ENABLE = st.laser_en;
  assign OPTICAL_SIGNAL_LOST = st.los;
  assign RX_CDR_ENGAGE = st.cdr_en;
  assign REG_RDATA = st.rdata;
  assign REG_RVALID = st.rvalid;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  fault_raises_a: assert property (
    LASER_FAULT |=> (!TX_FAULT_OE && !LASER_ENABLE))
    else $error("Laser fault did not raise fault and stop laser.");

  fault_level_a: assert property (
    TX_FAULT_OE == !st.fault)
    else $error("Fault pin level disagrees with fault state.");

  fault_latched_a: assert property (
    (st.fault && !(st.dis_prev && !TX_DISABLE_PIN)) |=> (st.fault && !TX_FAULT_OE))
    else $error("Fault released without a shutoff toggle.");

  fault_clears_a: assert property (
    (st.fault && st.dis_prev && !TX_DISABLE_PIN && !LASER_FAULT && !EYE_UNSAFE)
      |=> (!st.fault && TX_FAULT_OE))
    else $error("Shutoff toggle did not clear the fault.");

  set_wins_a: assert property (
    (st.dis_prev && !TX_DISABLE_PIN && (LASER_FAULT || EYE_UNSAFE))
      |=> (st.fault && !LASER_ENABLE))
    else $error("A new fault lost against the shutoff toggle.");

  eye_off_a: assert property (
    EYE_UNSAFE |=> !LASER_ENABLE)
    else $error("Laser left on during unsafe condition.");

  cdr_follow_a: assert property (
    ##1 (RX_CDR_ENGAGE == $past(RX_SPEED_PIN)))
    else $error("Clock recovery engage does not follow speed select.");

  lock_gate_a: assert property (
    !RX_CDR_ENGAGE |=> !RX_CDR_LOCKED)
    else $error("Clock recovery locked while bypassed.");

  sig_lost_a: assert property (
    (!TRANSITION_OK |=> OPTICAL_SIGNAL_LOST) and (TRANSITION_OK |=> !OPTICAL_SIGNAL_LOST))
    else $error("Signal lost output wrong.");

  pin_off_a: assert property (
    TX_DISABLE_PIN |=> !LASER_ENABLE)
    else $error("Laser on while shutoff pin high.");

  laser_healthy_a: assert property (
    (!TX_DISABLE_PIN && !st.soft_dis && !st.fault
      && !LASER_FAULT && !EYE_UNSAFE && !REG_WR) |=> LASER_ENABLE)
    else $error("Laser stayed off with no reason to be off.");

  soft_off_a: assert property (
    (REG_WR && REG_ADDR == `OSL_STATUS_OFFSET && REG_WDATA[`OSL_BIT_SOFT_DIS])
      |=> (!LASER_ENABLE && st.soft_dis))
    else $error("Software shutoff did not stop the laser.");

  soft_clear_a: assert property (
    (REG_WR && hit && !REG_WDATA[`OSL_BIT_SOFT_DIS]) |=> !st.soft_dis)
    else $error("Software shutoff bit not cleared by a write.");

  soft_kept_a: assert property (
    !(REG_WR && hit) |=> $stable(st.soft_dis))
    else $error("Software shutoff bit changed without a write.");

  status_read_a: assert property (
    (REG_RD && REG_ADDR == `OSL_STATUS_OFFSET) |=> (REG_RVALID
      && REG_RDATA[`OSL_BIT_TX_FAULT] == $past(st.fault)
      && REG_RDATA[`OSL_BIT_SIG_LOST] == $past(st.los)))
    else $error("Status read does not show current fault and loss.");

  status_fault_a: assert property (
    (REG_RD && hit) |=> (REG_RDATA[`OSL_BIT_TX_FAULT] == !$past(TX_FAULT_OE)))
    else $error("Status fault bit disagrees with the fault pin.");

  status_lost_a: assert property (
    (REG_RD && hit) |=> (REG_RDATA[`OSL_BIT_SIG_LOST] == $past(OPTICAL_SIGNAL_LOST)))
    else $error("Status signal lost bit disagrees with the output.");

  status_dis_a: assert property (
    (REG_RD && hit) |=> (
      REG_RDATA[`OSL_BIT_DIS_STATE] == $past(TX_DISABLE_PIN || st.soft_dis)
      && REG_RDATA[`OSL_BIT_SOFT_DIS] == $past(st.soft_dis)))
    else $error("Status shutoff bits disagree with the shutoff state.");

  status_spare_a: assert property (
    (REG_RD && hit) |=> (REG_RDATA[5:3] == 3'h0 && REG_RDATA[0] == 1'h0))
    else $error("Unused status bits not zero.");

  unmapped_read_a: assert property (
    (REG_RD && !hit) |=> (REG_RVALID && REG_RDATA == `OSL_UNMAPPED_READ))
    else $error("Read of an unused address returned data.");

  rvalid_pulse_a: assert property (
    !REG_RD |=> !REG_RVALID)
    else $error("Read valid without a read.");

  fault_seen_c: cover property (LASER_FAULT ##1 st.fault ##[1:20] !st.fault);
  soft_dis_c: cover property (st.soft_dis && LASER_ENABLE == 1'b0);
  lock_seen_c: cover property (RX_CDR_ENGAGE ##1 RX_CDR_LOCKED);
  read_fault_c: cover property (REG_RVALID && REG_RDATA[`OSL_BIT_TX_FAULT]);
  unmapped_read_c: cover property ((REG_RD && !hit) ##1 REG_RVALID);
endmodule // osl_top
`default_nettype wire

/* File: osl_map.svh */
// Offsets, field positions, reset values and timing counts of the optical status logic.
`ifndef OSL_MAP_SVH
`define OSL_MAP_SVH

`define OSL_STATUS_OFFSET 8'h6E
`define OSL_BIT_DIS_STATE 7
`define OSL_BIT_SOFT_DIS 6
`define OSL_BIT_TX_FAULT 2
`define OSL_BIT_SIG_LOST 1
`define OSL_STATUS_RESET 8'h00
`define OSL_UNMAPPED_READ 8'h00
`define OSL_CLK_MHZ 200
`define OSL_LOCK_TIME_US 500
`define OSL_LOCK_CNT_W 17

`endif

/* File: osl_pkg.sv */
// Types shared by the optical status logic modules.
`default_nettype none
package osl_pkg;
  typedef struct packed {
    logic fault;
    logic dis_prev;
    logic soft_dis;
    logic laser_en;
    logic los;
    logic fault_oe;
    logic cdr_en;
    logic [7:0] rdata;
    logic rvalid;
  } osl_state_t;

  typedef struct packed {
    logic [16:0] cnt;
    logic done;
  } osl_timer_t;
endpackage
`default_nettype wire

/* File: osl_lock_timer.sv */
// Lock timer for the receive clock recovery stage.
`default_nettype none
`include "osl_map.svh"
module osl_lock_timer #(
  parameter int unsigned LIMIT = `OSL_LOCK_TIME_US * `OSL_CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  output logic done
);
  osl_pkg::osl_timer_t st;
  osl_pkg::osl_timer_t next_st;

  // The count restarts whenever traffic drops, and the lock clears on the clock edge after traffic drops.
  always_comb begin
    next_st = st;
    if (!en) begin
      next_st.cnt = '0;
      next_st.done = 1'b0;
    end else if (!st.done) begin
      if (st.cnt == `OSL_LOCK_CNT_W'(LIMIT - 1)) begin
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt + `OSL_LOCK_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done = st.done;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  lock_on_limit_a: assert property (
    (en && !st.done && st.cnt == `OSL_LOCK_CNT_W'(LIMIT - 1)) |=> done)
    else $error("Lock not taken at the end of the count.");
  lock_needs_en_a: assert property (
    !en |=> !done)
    else $error("Lock held without traffic.");
endmodule // osl_lock_timer
`default_nettype wire

/* File: osl_host_model.sv */
// Host board side of the status pins: pull-up on the open-collector fault line.
`default_nettype none
module osl_host_model (
  input wire logic oe,
  input wire logic od,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  // host pull-up
  // A released line rises to the pull-up level and never keeps an old value.
  assign line = oe ? od : 1'b1;
endmodule // osl_host_model
`default_nettype wire

/* File: tb_osl_top.sv */
// Self-checking testbench of the optical status logic.
`default_nettype none
module tb_osl_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned LK = 8;
  logic clk, rst, dis, flt, eye, tok, spd, trf, wr, rd, line, fo, foe, las, los, eng, lck, rv;
  logic [7:0] addr, wd, rdat;
  int mismatches, total_checks;
  osl_top #(.LOCK_CYCLES(LK)) dut (.CLK(clk), .RESET(rst), .TX_DISABLE_PIN(dis),
    .LASER_FAULT(flt), .EYE_UNSAFE(eye), .TRANSITION_OK(tok), .RX_SPEED_PIN(spd),
    .RX_TRAFFIC_VALID(trf), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wd),
    .TX_FAULT_O(fo), .TX_FAULT_OE(foe), .LASER_ENABLE(las), .OPTICAL_SIGNAL_LOST(los),
    .RX_CDR_ENGAGE(eng), .RX_CDR_LOCKED(lck), .REG_RDATA(rdat), .REG_RVALID(rv));
  osl_host_model host (.oe(foe), .od(fo), .line(line));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [7:0] stat(logic d, logic s, logic f, logic l);
    return {d | s, s, 3'h0, f, l, 1'h0};
  endfunction
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rdb(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", rdat, e);
    chk("rvalid", rv, 8'h01);
    @(negedge clk);
    chk("rvalid", rv, 8'h00);
  endtask
  task automatic wrb(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic tog();
    @(posedge clk);
    dis <= 1'b1;
    @(posedge clk);
    dis <= 1'b0;
    cyc(2);
    @(negedge clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #20us;
    mismatches++;
    conclude();
  end
  initial begin
    void'($urandom(32'hD63632B0));
    {rst, dis, flt, eye, tok, spd, trf, wr, rd, addr, wd} = {2'h3, 23'h0};
    cyc(4);
    rst <= 1'b0;
    @(negedge clk);
    chk("laser", las, 8'h00);
    @(posedge clk);
    dis <= 1'b0;
    tok <= 1'b1;
    cyc(2);
    @(negedge clk);
    chk("laser", las, 8'h01);
    chk("line", line, 8'h00);
    @(posedge clk);
    flt <= 1'b1;
    @(posedge clk);
    flt <= 1'b0;
    cyc(3);
    @(negedge clk);
    chk("line", line, 8'h01);
    chk("laser", las, 8'h00);
    rdb(8'h6E, stat(0, 0, 1, 0));
    tog();
    chk("laser", las, 8'h01);
    chk("line", line, 8'h00);
    @(posedge clk);
    eye <= 1'b1;
    cyc(2);
    @(negedge clk);
    chk("laser", las, 8'h00);
    @(posedge clk);
    eye <= 1'b0;
    dis <= 1'b1;
    @(posedge clk);
    dis <= 1'b0;
    flt <= 1'b1;
    @(posedge clk);
    flt <= 1'b0;
    cyc(2);
    @(negedge clk);
    chk("line", line, 8'h01);
    tog();
    wrb(8'h21, 8'hFF);
    rdb(8'h21, 8'h00);
    chk("laser", las, 8'h01);
    wrb(8'h6E, 8'h40);
    @(negedge clk);
    chk("laser", las, 8'h00);
    rdb(8'h6E, stat(0, 1, 0, 0));
    wrb(8'h6E, 8'h00);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      tok <= 1'($urandom_range(1));
      spd <= 1'($urandom_range(1));
      cyc(2);
      @(negedge clk);
      chk("sig_lost", los, {7'h0, ~tok});
      chk("engage", eng, {7'h0, spd});
      rdb(8'h6E, stat(0, 0, 0, ~tok));
    end
    @(posedge clk);
    spd <= 1'b1;
    cyc(2);
    trf <= 1'b1;
    cyc(LK - 1);
    @(negedge clk);
    chk("locked", lck, 8'h00);
    cyc(1);
    @(negedge clk);
    chk("locked", lck, 8'h01);
    @(posedge clk);
    trf <= 1'b0;
    cyc(1);
    @(negedge clk);
    chk("locked", lck, 8'h00);
    wrb(8'h6E, 8'h40);
    @(posedge clk);
    flt <= 1'b1;
    spd <= 1'b0;
    @(posedge clk);
    flt <= 1'b0;
    dis <= 1'b1;
    tok <= 1'b0;
    @(negedge clk);
    chk("line", line, 8'h01);
    @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    chk("line", line, 8'h00);
    cyc(2);
    rst <= 1'b0;
    @(negedge clk);
    chk("laser", las, 8'h00);
    chk("sig_lost", los, 8'h01);
    chk("engage", eng, 8'h00);
    chk("locked", lck, 8'h00);
    chk("rvalid", rv, 8'h00);
    chk("rdata", rdat, 8'h00);
    @(posedge clk);
    dis <= 1'b0;
    cyc(2);
    @(negedge clk);
    chk("laser", las, 8'h01);
    rdb(8'h6E, stat(0, 0, 0, 1));
    conclude();
  end
endmodule // tb_osl_top
`default_nettype wire
